//--- rtl/ctm_params.svh
`ifndef CTM_PARAMS_SVH
`define CTM_PARAMS_SVH

`define CTM_CLK_MHZ       200
`define CTM_SENSE_ONE_NS  1060000
`define CTM_SENSE_TWO_NS  1297000
`define CTM_NS_TO_CYC(ns) ((((ns) * `CTM_CLK_MHZ) + 999) / 1000)
`define CTM_SENSE_ONE_CYC `CTM_NS_TO_CYC(`CTM_SENSE_ONE_NS)
`define CTM_SENSE_TWO_CYC `CTM_NS_TO_CYC(`CTM_SENSE_TWO_NS)
`define CTM_WIN_W         20
`define CTM_HOLD_W        16
`define CTM_BCD_W         8
`define CTM_SYNC_W        2

`endif

//--- rtl/ctm_pkg.sv
package ctm_pkg;
    typedef enum logic [1:0]
    {
        CTM_HOLDING = 2'h0,
        CTM_ARMED   = 2'h1
    } ctm_phase_t;

    typedef enum logic [1:0]
    {
        CTM_IDLE  = 2'h0,
        CTM_SENSE = 2'h1
    } ctm_sense_t;

    typedef enum logic [1:0]
    {
        CTM_V_NOW_TIME = 2'h0,
        CTM_V_NOW_DATE = 2'h1,
        CTM_V_EVT_DATE = 2'h3,
        CTM_V_EVT_TIME = 2'h2
    } ctm_view_t;
endpackage : ctm_pkg

//--- rtl/ctm_sensor_sampler.sv
`timescale 1ns/100ps
`include "ctm_params.svh"
module ctm_sensor_sampler
    import ctm_pkg::*;
#(
    parameter logic [`CTM_WIN_W-1:0] ONE_CYC =
        `CTM_WIN_W'(`CTM_SENSE_ONE_CYC),
    parameter logic [`CTM_WIN_W-1:0] TWO_CYC =
        `CTM_WIN_W'(`CTM_SENSE_TWO_CYC)
)
(
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic sec_tick,
    input  wire logic two_coil,
    input  wire logic sensor_out_raw,
    output logic      sensor_enable,
    output logic      sample_valid,
    output logic      sample_open
);
    typedef struct packed {
        logic [`CTM_SYNC_W-1:0] sync;
        ctm_sense_t             st;
        logic [`CTM_WIN_W-1:0]  cnt;
        logic                   en;
        logic                   valid;
        logic                   open;
    } ctm_smp_t;

    ctm_smp_t q;
    ctm_smp_t d;

    always_comb
    begin
        d = q;
        d.sync = {q.sync[0], sensor_out_raw};
        d.valid = 1'b0;
        case (q.st)
            CTM_IDLE:
            begin
                if (sec_tick)
                begin
                    d.st = CTM_SENSE;
                    d.en = 1'b1;
                    d.cnt = two_coil ? TWO_CYC - 1'b1 : ONE_CYC - 1'b1;
                end
            end
            CTM_SENSE:
            begin
                if (q.cnt == '0)
                begin
                    // Read at window end so the switch has settled
                    d.st = CTM_IDLE;
                    d.en = 1'b0;
                    d.valid = 1'b1;
                    d.open = q.sync[1];
                end
                else
                begin
                    d.cnt = q.cnt - 1'b1;
                end
            end
            default:
            begin
                d.st = CTM_IDLE;
                d.en = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            q <= '0;
        else
            q <= d;
    end

    assign sensor_enable = q.en;
    assign sample_valid  = q.valid;
    assign sample_open   = q.open;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    tick_starts_en_a: assert property (
        q.st == CTM_IDLE && sec_tick |=> sensor_enable)
        else $error("sensor not enabled after tick");
    window_end_a: assert property (
        $fell(sensor_enable) |-> sample_valid && q.st == CTM_IDLE)
        else $error("window closed without a sample");
    sample_sync_a: assert property (
        sample_valid |-> sample_open == $past(q.sync[1]))
        else $error("sample not from second sync stage");
endmodule : ctm_sensor_sampler

//--- rtl/case_tamper_monitor.sv
`timescale 1ns/100ps
`include "ctm_params.svh"
module case_tamper_monitor
    import ctm_pkg::*;
#(
    parameter logic [`CTM_WIN_W-1:0] SENSE_ONE_CYC =
        `CTM_WIN_W'(`CTM_SENSE_ONE_CYC),
    parameter logic [`CTM_WIN_W-1:0] SENSE_TWO_CYC =
        `CTM_WIN_W'(`CTM_SENSE_TWO_CYC)
)
(
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    input  wire logic                  sec_tick,
    input  wire logic [`CTM_HOLD_W-1:0] holdoff_secs,
    input  wire logic                  sel_one_coil,
    input  wire logic                  sel_two_coil,
    input  wire logic                  sensor_out_raw,
    input  wire logic                  main_supply,
    input  wire logic                  backup_supply,
    input  wire logic                  first_event_clear_button,
    input  wire logic [`CTM_BCD_W-1:0] cal_hour,
    input  wire logic [`CTM_BCD_W-1:0] cal_min,
    input  wire logic [`CTM_BCD_W-1:0] cal_sec,
    input  wire logic [`CTM_BCD_W-1:0] cal_year,
    input  wire logic [`CTM_BCD_W-1:0] cal_month,
    input  wire logic [`CTM_BCD_W-1:0] cal_day,
    input  wire ctm_view_t             disp_sel,
    output logic                       sensor_enable,
    output logic                       open_now_indicator,
    output logic                       tamper_latched_indicator,
    output logic                       holdoff_blink_indicator,
    output logic                       variant_error,
    output ctm_view_t                  disp_top_label,
    output logic                       disp_bot_none,
    output logic [`CTM_BCD_W-1:0]      disp_bot_hi,
    output logic [`CTM_BCD_W-1:0]      disp_bot_mid,
    output logic [`CTM_BCD_W-1:0]      disp_bot_lo,
    output logic                       icon_timer,
    output logic                       icon_boxed_r,
    output logic                       icon_case_open,
    output logic                       icon_backup
);
    typedef struct packed {
        logic [`CTM_SYNC_W-1:0] main_s;
        logic [`CTM_SYNC_W-1:0] bak_s;
        logic [`CTM_SYNC_W-1:0] clr_s;
        logic                   clr_prev;
        ctm_phase_t             phase;
        logic [`CTM_HOLD_W-1:0] secs;
        logic                   blink;
        logic                   case_open;
        logic                   open_led;
        logic                   latched;
        logic                   rec_valid;
        logic [`CTM_BCD_W-1:0]  e_hr;
        logic [`CTM_BCD_W-1:0]  e_mn;
        logic [`CTM_BCD_W-1:0]  e_sc;
        logic [`CTM_BCD_W-1:0]  e_yr;
        logic [`CTM_BCD_W-1:0]  e_mo;
        logic [`CTM_BCD_W-1:0]  e_dy;
        ctm_view_t              top;
        logic                   none;
        logic [`CTM_BCD_W-1:0]  hi;
        logic [`CTM_BCD_W-1:0]  mid;
        logic [`CTM_BCD_W-1:0]  lo;
        logic                   tmr;
        logic                   box;
        logic                   ico_open;
        logic                   ico_bak;
        logic                   var_err;
    } ctm_state_t;

    ctm_state_t q;
    ctm_state_t d;

    logic variant_ok;
    logic smp_valid;
    logic smp_open;
    logic clr_rise;
    logic evt;

    function automatic logic ctm_rise(input logic cur, input logic prev);
        return cur & ~prev;
    endfunction : ctm_rise

    // A wrong strap leaves the switch unpowered rather than misread
    assign variant_ok = sel_one_coil ^ sel_two_coil;

    ctm_sensor_sampler #(
        .ONE_CYC (SENSE_ONE_CYC),
        .TWO_CYC (SENSE_TWO_CYC)
    ) u_sampler (
        .sys_clk        (sys_clk),
        .rst            (rst),
        .sec_tick       (sec_tick & variant_ok),
        .two_coil       (sel_two_coil),
        .sensor_out_raw (sensor_out_raw),
        .sensor_enable  (sensor_enable),
        .sample_valid   (smp_valid),
        .sample_open    (smp_open)
    );

    assign clr_rise = ctm_rise(q.clr_s[1], q.clr_prev);
    // Only a closed-to-open transition counts as a new event
    assign evt = q.phase == CTM_ARMED && smp_valid &&
                 ctm_rise(smp_open, q.case_open);

    always_comb
    begin
        d = q;
        d.main_s = {q.main_s[0], main_supply};
        d.bak_s = {q.bak_s[0], backup_supply};
        d.clr_s = {q.clr_s[0], first_event_clear_button};
        d.clr_prev = q.clr_s[1];
        d.var_err = ~variant_ok;
        if (smp_valid)
            d.case_open = smp_open;

        case (q.phase)
            CTM_HOLDING:
            begin
                if (q.secs >= holdoff_secs)
                begin
                    d.phase = CTM_ARMED;
                    d.blink = 1'b0;
                end
                else if (sec_tick)
                begin
                    d.secs = q.secs + 1'b1;
                    d.blink = ~q.blink;
                end
            end
            CTM_ARMED:
            begin
                d.blink = 1'b0;
            end
            default:
            begin
                d.phase = CTM_HOLDING;
            end
        endcase

        if (clr_rise)
            d.rec_valid = 1'b0;
        // Placed after the clear so a same-cycle event is kept
        if (evt)
        begin
            d.latched = 1'b1;
            if (!d.rec_valid)
            begin
                d.rec_valid = 1'b1;
                d.e_hr = cal_hour;
                d.e_mn = cal_min;
                d.e_sc = cal_sec;
                d.e_yr = cal_year;
                d.e_mo = cal_month;
                d.e_dy = cal_day;
            end
        end

        d.open_led = q.phase == CTM_ARMED && q.main_s[1] &&
                     q.case_open;
        d.ico_open = q.case_open;
        d.ico_bak = q.bak_s[1];

        d.top = disp_sel;
        d.tmr = ~disp_sel[1];
        d.box = disp_sel[1];
        d.none = disp_sel[1] & ~q.rec_valid;
        case (disp_sel)
            CTM_V_NOW_TIME:
            begin
                d.hi = cal_hour;
                d.mid = cal_min;
                d.lo = cal_sec;
            end
            CTM_V_NOW_DATE:
            begin
                d.hi = cal_year;
                d.mid = cal_month;
                d.lo = cal_day;
            end
            CTM_V_EVT_TIME:
            begin
                d.hi = q.e_hr;
                d.mid = q.e_mn;
                d.lo = q.e_sc;
            end
            default:
            begin
                d.hi = q.e_yr;
                d.mid = q.e_mo;
                d.lo = q.e_dy;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            q <= '0;
        else
            q <= d;
    end

    assign open_now_indicator       = q.open_led;
    assign tamper_latched_indicator = q.latched & q.main_s[1];
    assign holdoff_blink_indicator  = q.blink;
    assign variant_error            = q.var_err;
    assign disp_top_label           = q.top;
    assign disp_bot_none            = q.none;
    assign disp_bot_hi              = q.hi;
    assign disp_bot_mid             = q.mid;
    assign disp_bot_lo              = q.lo;
    assign icon_timer               = q.tmr;
    assign icon_boxed_r             = q.box;
    assign icon_case_open           = q.ico_open;
    assign icon_backup              = q.ico_bak;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    live_open_open_now_indicator: assert property (
        open_now_indicator |-> $past(q.phase == CTM_ARMED &&
                                     q.main_s[1] && q.case_open))
        else $error("live open light without cause");
    latch_holds_a: assert property (
        q.latched |=> q.latched)
        else $error("tamper latch dropped");
    blink_tick_a: assert property (
        q.phase == CTM_HOLDING && $changed(q.blink) |-> $past(sec_tick))
        else $error("blink toggled without a tick");
    blink_off_a: assert property (
        q.phase == CTM_ARMED |=> !holdoff_blink_indicator [*2])
        else $error("blink still active after hold-off");
    no_early_latch_a: assert property (
        q.phase == CTM_HOLDING |-> !q.latched)
        else $error("tamper latched during hold-off");
    record_stamp_a: assert property (
        evt && !q.rec_valid |=> q.rec_valid && q.e_sc == $past(cal_sec)
                                && q.e_dy == $past(cal_day))
        else $error("first event stamp not captured");
    none_shown_a: assert property (
        disp_sel[1] && !q.rec_valid && !evt |=> disp_bot_none)
        else $error("None not shown for empty record");
    clear_record_a: assert property (
        clr_rise && !evt |=> !q.rec_valid)
        else $error("clear did not discard the record");
    variant_block_a: assert property (
        !variant_ok && !sensor_enable |=> !sensor_enable)
        else $error("switch enabled with bad variant straps");

    event_cover_c: cover property (evt && !q.rec_valid);
    clear_cover_c: cover property (clr_rise ##[1:50] evt);
    arm_cover_c:   cover property ($rose(q.phase == CTM_ARMED));
endmodule : case_tamper_monitor

//--- sim/ctm_switch_model.sv
`timescale 1ns/100ps
module ctm_switch_model
#(
    parameter int SETTLE = 2
)
(
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic sensor_enable,
    input  wire logic case_open,
    output logic      sensor_out_raw
);
    typedef struct packed
    {
        logic [2:0] on;
        logic       junk;
    } ctm_sw_t;

    ctm_sw_t sw_q;
    ctm_sw_t sw_d;

    // Output is garbage while unpowered or settling, never the last value
    always_comb
    begin
        sw_d = sw_q;
        sw_d.junk = ~sw_q.junk;
        if (!sensor_enable)
            sw_d.on = 3'h0;
        else if (sw_q.on != 3'h7)
            sw_d.on = sw_q.on + 3'h1;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            sw_q <= '0;
        else
            sw_q <= sw_d;
    end

    assign sensor_out_raw = (int'(sw_q.on) >= SETTLE) ? case_open : sw_q.junk;
endmodule : ctm_switch_model

//--- sim/testbench.sv
`timescale 1ns/100ps
module testbench
    import ctm_pkg::*;
;
    logic sys_clk, rst, sec_tick, sel_one_coil, sel_two_coil, sensor_out_raw;
    logic main_supply, backup_supply, first_event_clear_button, case_open;
    logic [15:0] holdoff_secs;
    logic [7:0] cal_hour, cal_min, cal_sec, cal_year, cal_month, cal_day;
    ctm_view_t disp_sel, disp_top_label;
    logic sensor_enable, open_now_indicator, tamper_latched_indicator;
    logic holdoff_blink_indicator, variant_error, disp_bot_none;
    logic icon_timer, icon_boxed_r, icon_case_open, icon_backup;
    logic [7:0] disp_bot_hi, disp_bot_mid, disp_bot_lo;
    int failures, checks, n_en;

    case_tamper_monitor #(.SENSE_ONE_CYC(20'h8), .SENSE_TWO_CYC(20'hA)) dut
    (
        .sys_clk, .rst, .sec_tick, .holdoff_secs, .sel_one_coil,
        .sel_two_coil, .sensor_out_raw, .main_supply, .backup_supply,
        .first_event_clear_button, .cal_hour, .cal_min, .cal_sec,
        .cal_year, .cal_month, .cal_day, .disp_sel, .sensor_enable,
        .open_now_indicator, .tamper_latched_indicator,
        .holdoff_blink_indicator, .variant_error, .disp_top_label,
        .disp_bot_none, .disp_bot_hi, .disp_bot_mid, .disp_bot_lo,
        .icon_timer, .icon_boxed_r, .icon_case_open, .icon_backup
    );

    ctm_switch_model #(.SETTLE(2)) sw
    (
        .sys_clk, .rst, .sensor_enable, .case_open, .sensor_out_raw
    );

    task check(input logic [23:0] seen, input logic [23:0] exp);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check

    task test_done;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : test_done

    // Fixed span covers the longest window plus sync and update
    // Enable rises at the edge that takes the tick, so count from there
    task tick(input int exp_n);
        n_en = 0;
        sec_tick = 1'b1;
        repeat (31)
        begin
            @(negedge sys_clk);
            sec_tick = 1'b0;
            n_en += int'(sensor_enable === 1'b1);
        end
        check(24'(n_en), 24'(exp_n));
    endtask : tick

    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    initial
    begin
        failures = 0;
        checks = 0;
        rst = 1'b1;
        sec_tick = 1'b0;
        holdoff_secs = 16'h0002;
        sel_one_coil = 1'b1;
        sel_two_coil = 1'b0;
        main_supply = 1'b1;
        backup_supply = 1'b0;
        first_event_clear_button = 1'b0;
        case_open = 1'b1;
        {cal_hour, cal_min, cal_sec} = 24'h123456;
        {cal_year, cal_month, cal_day} = 24'h240719;
        disp_sel = CTM_V_EVT_TIME;
        repeat (2) @(negedge sys_clk);
        check({open_now_indicator, tamper_latched_indicator}, 24'h0);
        rst = 1'b0;
        repeat (3) @(negedge sys_clk);
        check(disp_bot_none, 1'b1);
        check({icon_timer, icon_boxed_r}, 2'b01);
        tick(8);
        check(holdoff_blink_indicator, 1'b1);
        tick(8);
        check(holdoff_blink_indicator, 1'b0);
        check(tamper_latched_indicator, 1'b0);
        $display("hold-off test done");
        case_open = 1'b0;
        tick(8);
        check({open_now_indicator, holdoff_blink_indicator}, 2'b00);
        case_open = 1'b1;
        tick(8);
        check({open_now_indicator, tamper_latched_indicator,
               icon_case_open}, 3'b111);
        check({disp_bot_hi, disp_bot_mid}, 16'h1234);
        check({disp_bot_none, disp_bot_lo}, 9'h056);
        cal_sec = 8'h59;
        cal_day = 8'h20;
        case_open = 1'b0;
        tick(8);
        check({open_now_indicator, tamper_latched_indicator}, 2'b01);
        check(disp_bot_lo, 8'h56);
        disp_sel = CTM_V_EVT_DATE;
        repeat (2) @(negedge sys_clk);
        check({disp_bot_hi, disp_bot_mid, disp_bot_lo}, 24'h240719);
        check(disp_top_label, 2'h3);
        disp_sel = CTM_V_NOW_TIME;
        repeat (2) @(negedge sys_clk);
        check({disp_bot_hi, disp_bot_mid, disp_bot_lo}, 24'h123459);
        check({icon_timer, icon_boxed_r, disp_top_label}, 4'h8);
        disp_sel = CTM_V_NOW_DATE;
        repeat (2) @(negedge sys_clk);
        check({disp_bot_hi, disp_bot_mid, disp_bot_lo}, 24'h240720);
        check({icon_timer, icon_boxed_r, disp_top_label}, 4'h9);
        $display("record test done");
        first_event_clear_button = 1'b1;
        repeat (6) @(negedge sys_clk);
        first_event_clear_button = 1'b0;
        disp_sel = CTM_V_EVT_TIME;
        repeat (2) @(negedge sys_clk);
        check(disp_bot_none, 1'b1);
        check(tamper_latched_indicator, 1'b1);
        case_open = 1'b1;
        cal_sec = 8'h11;
        tick(8);
        check(disp_bot_lo, 8'h11);
        main_supply = 1'b0;
        backup_supply = 1'b1;
        repeat (4) @(negedge sys_clk);
        check({tamper_latched_indicator, open_now_indicator,
               icon_backup}, 3'b001);
        main_supply = 1'b1;
        backup_supply = 1'b0;
        $display("clear and supply test done");
        sel_one_coil = 1'b0;
        sel_two_coil = 1'b1;
        tick(10);
        sel_one_coil = 1'b1;
        tick(0);
        check(variant_error, 1'b1);
        rst = 1'b1;
        @(negedge sys_clk);
        rst = 1'b0;
        repeat (3) @(negedge sys_clk);
        check(tamper_latched_indicator, 1'b0);
        $display("variant and reset test done");
        test_done();
    end
endmodule : testbench
